// ===== mcad_regs.vh
`ifndef MCAD_REGS_VH
`define MCAD_REGS_VH

// Instruction opcodes and fixed fields
`define MCAD_OP_ADD        6'h0a
`define MCAD_OP_ADDI       6'h06
`define MCAD_OP_AND        13'h05d9
`define MCAD_OP_BIAS       11'h1b1

// ALU operand set codes
`define MCAD_ALU_R4        3'h4
`define MCAD_ALU_LIT       3'h5
`define MCAD_ALU_MULH      3'h6
`define MCAD_ALU_MULL      3'h7

// Bias selector codes
`define MCAD_BT_LS5        4'h9
`define MCAD_BT_HS2S       4'ha
`define MCAD_BT_HS4S       4'hb
`define MCAD_BT_LS6        4'hc
`define MCAD_BT_ALL        4'hd
`define MCAD_BT_HS         4'he
`define MCAD_BT_LS         4'hf

// Bias structure mask positions: hs1..hs5, ls1..ls6, hs2 strong, hs4 strong
`define MCAD_BIAS_W        13
`define MCAD_BIAS_HS_MASK  13'h181f
`define MCAD_BIAS_LS_MASK  13'h07e0
`define MCAD_BIAS_ALL_MASK 13'h1fff

// Condition flag bit positions
`define MCAD_FL_C          0
`define MCAD_FL_ZERO       1
`define MCAD_FL_NEG        2
`define MCAD_FL_ULOW       3
`define MCAD_FL_UHIGH      4
`define MCAD_FL_SLOW       5
`define MCAD_FL_SO         6
`define MCAD_FL_MZERO      7
`define MCAD_FL_MONES      8
`define MCAD_FL_DENY       9
`define MCAD_FLAGS_W       10
`define MCAD_FLAGS_RST     10'h000

// Register byte addresses, access configuration word indices and reset value
`define MCAD_ADDR_ALU_BASE 12'h000
`define MCAD_ADDR_FLAGS    12'h020
`define MCAD_ADDR_BIAS     12'h024
`define MCAD_ADDR_PROBE    12'h028
`define MCAD_IDX_ACC0      12'h184
`define MCAD_IDX_ACC3      12'h187
`define MCAD_ACC_RST       16'h0000

// AXI responses
`define MCAD_RESP_OKAY     2'b00
`define MCAD_RESP_SLVERR   2'b10

`endif

// ===== mcad_core.v
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "mcad_regs.vh"

module mcad_core #(
  parameter CORE_ID = 0,
  parameter DATA_W  = 16,
  parameter ADDR_W  = 12
) (
  input  wire                    clk_i,
  input  wire                    resetn_i,
  input  wire [15:0]             instr_i,
  input  wire                    instr_valid_i,
  output reg  [`MCAD_BIAS_W-1:0] bias_en_o,
  output reg  [`MCAD_FLAGS_W-1:0] cond_flags_o,
  input  wire [ADDR_W-1:0]       s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [ADDR_W-1:0]       s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready
);

  // Class of a five-bit core register code: [8:5] class, [2:0] index in class
  function [8:0] core_reg_class;
    input [4:0] code;
    begin
      casez (code)
        5'b00???: core_reg_class = {4'h0, 2'b00, code[2:0]};
        5'b01000: core_reg_class = {4'h1, 5'h00};
        5'b01001: core_reg_class = {4'h2, 5'h00};
        5'b0101?: core_reg_class = {4'h3, 4'h0, code[0]};
        5'b011??: core_reg_class = {4'h4, 3'h0, code[1:0]};
        5'b100??: core_reg_class = {4'h5, 3'h0, code[1:0]};
        5'b10100: core_reg_class = {4'h6, 5'h00};
        5'b10101: core_reg_class = {4'h7, 5'h00};
        5'b10110: core_reg_class = {4'h8, 5'h00};
        5'b10111: core_reg_class = {4'h9, 5'h00};
        5'b11101: core_reg_class = {4'hb, 5'h00};
        5'b11110: core_reg_class = {4'hc, 5'h00};
        5'b11111: core_reg_class = {4'hd, 5'h00};
        default:  core_reg_class = {4'ha, 2'b00, code[2:0]};
      endcase
    end
  endfunction

  // Restricted general operand: r0-r4 and literal holder only
  function general_ok;
    input [2:0] code;
    begin
      general_ok = (code <= `MCAD_ALU_LIT);
    end
  endfunction

  // Bias selector to structure mask
  function [`MCAD_BIAS_W-1:0] bias_decode;
    input [3:0] sel;
    begin
      case (sel)
        `MCAD_BT_HS2S: bias_decode = 13'h0800;
        `MCAD_BT_HS4S: bias_decode = 13'h1000;
        `MCAD_BT_LS6:  bias_decode = 13'h0400;
        `MCAD_BT_ALL:  bias_decode = `MCAD_BIAS_ALL_MASK;
        `MCAD_BT_HS:   bias_decode = `MCAD_BIAS_HS_MASK;
        `MCAD_BT_LS:   bias_decode = `MCAD_BIAS_LS_MASK;
        default:       bias_decode = 13'h0001 << sel;
      endcase
    end
  endfunction

  // Jump register operand: one-hot pick of the two jump targets
  function [1:0] jump_register_operand_set;
    input code;
    begin
      jump_register_operand_set = code ? 2'b10 : 2'b01;
    end
  endfunction

  // Byte address inside the ALU operand set window
  function alu_hit;
    input [ADDR_W-1:0] addr;
    begin
      alu_hit = addr[11:5] == 7'h00;
    end
  endfunction

  // Word index inside the output access configuration window
  function acc_hit;
    input [9:0] word;
    begin
      acc_hit = {2'b00, word} >= `MCAD_IDX_ACC0 && {2'b00, word} <= `MCAD_IDX_ACC3;
    end
  endfunction

  // ALU operand set: index 0-4 r0-r4, 5 literal holder, 6/7 multiply words
  reg [DATA_W-1:0] alu_operand_set_reg [0:7];
  reg [15:0]       output_access_config_reg [0:3];
  reg [5:0]        probe_reg;

  // Instruction fields
  wire [2:0] first_source  = instr_i[2:0];
  wire [2:0] second_source = instr_i[5:3];
  wire [2:0] result_sel    = instr_i[9:7];
  wire [3:0] add_literal   = instr_i[6:3];
  wire       bias_state    = instr_i[4];
  wire [3:0] bias_selector = instr_i[3:0];

  wire is_add  = instr_valid_i && instr_i[15:10] == `MCAD_OP_ADD &&
                 !instr_i[6];
  wire is_addi = instr_valid_i && instr_i[15:10] == `MCAD_OP_ADDI;
  wire is_and  = instr_valid_i && instr_i[15:3] == `MCAD_OP_AND;
  wire is_bias = instr_valid_i && instr_i[15:5] == `MCAD_OP_BIAS;

  // Adder shared by add and add-immediate
  wire [DATA_W-1:0] add_a = alu_operand_set_reg[first_source];
  wire [DATA_W-1:0] add_b = is_addi ? {{(DATA_W-4){1'b0}}, add_literal}
                                    : alu_operand_set_reg[second_source];
  wire [DATA_W:0]   add_full = {1'b0, add_a} + {1'b0, add_b};
  wire [DATA_W-1:0] add_sum  = add_full[DATA_W-1:0];
  wire [DATA_W-1:0] alu_literal_holder = alu_operand_set_reg[`MCAD_ALU_LIT];
  wire [DATA_W-1:0] mask_res = add_a & alu_literal_holder;

  // Condition flags of the shared adder and of the mask
  wire add_carry          = add_full[DATA_W];
  wire sum_zero_bit       = add_sum == {DATA_W{1'b0}};
  wire sum_negative_bit   = add_sum[DATA_W-1];
  // Unsigned underflow cannot arise from an addition
  wire unsigned_low_wrap  = 1'b0;
  wire unsigned_high_wrap = add_full[DATA_W];
  wire signed_low_wrap    = add_a[DATA_W-1] & add_b[DATA_W-1] & ~add_sum[DATA_W-1];
  wire signed_high_wrap   = ~add_a[DATA_W-1] & ~add_b[DATA_W-1] & add_sum[DATA_W-1];
  wire mask_all_zero      = mask_res == {DATA_W{1'b0}};
  wire mask_all_ones      = mask_res == {DATA_W{1'b1}};

  // Drive rights of this core; strong structures follow their high-side output
  wire [15:0]             acc_word    = output_access_config_reg[CORE_ID];
  wire [`MCAD_BIAS_W-1:0] drive_right = {acc_word[3], acc_word[1], acc_word[10:0]};
  wire [`MCAD_BIAS_W-1:0] bias_sel    = bias_decode(bias_selector);
  wire [`MCAD_BIAS_W-1:0] bias_allow  = bias_sel & drive_right;

  // Bus write path
  reg              aw_got_reg;
  reg              w_got_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0]       w_data_reg;
  reg [3:0]        w_strb_reg;
  wire             wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire [15:0]      wr_lo = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
                            w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
  wire [1:0]       wr_lo_en = w_strb_reg[1:0];
  wire [9:0]       wr_word  = aw_addr_reg[11:2];
  wire             wr_alu   = wr_do && alu_hit(aw_addr_reg);
  wire             wr_acc   = wr_do && acc_hit(wr_word);
  wire             wr_probe = wr_do && aw_addr_reg == `MCAD_ADDR_PROBE;
  wire             wr_ok    = wr_alu || wr_acc || wr_probe ||
                              aw_addr_reg == `MCAD_ADDR_FLAGS ||
                              aw_addr_reg == `MCAD_ADDR_BIAS;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  en;
    begin
      merge16 = {en[1] ? nw[15:8] : old[15:8], en[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  integer i;
  integer j;

  // Register file: instruction results override a same-cycle bus write
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        alu_operand_set_reg[i] <= {DATA_W{1'b0}};
      end
    end else begin
      if (wr_alu) begin
        alu_operand_set_reg[aw_addr_reg[4:2]] <=
          merge16(alu_operand_set_reg[aw_addr_reg[4:2]], wr_lo, wr_lo_en);
      end
      if (is_add || is_addi) begin
        alu_operand_set_reg[result_sel] <= add_sum;
      end else if (is_and) begin
        alu_operand_set_reg[first_source] <= mask_res;
      end
    end
  end

  // Condition flags, bias state and access configuration
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cond_flags_o <= `MCAD_FLAGS_RST;
      bias_en_o    <= {`MCAD_BIAS_W{1'b0}};
      probe_reg    <= 6'h00;
      for (j = 0; j < 4; j = j + 1) begin
        output_access_config_reg[j] <= `MCAD_ACC_RST;
      end
    end else begin
      if (wr_acc) begin
        output_access_config_reg[wr_word[1:0]] <=
          merge16(output_access_config_reg[wr_word[1:0]], wr_lo, wr_lo_en);
      end
      if (wr_probe && wr_lo_en[0]) begin
        probe_reg <= wr_lo[5:0];
      end
      if (is_add || is_addi) begin
        cond_flags_o[`MCAD_FL_C]     <= add_carry;
        cond_flags_o[`MCAD_FL_ZERO]  <= sum_zero_bit;
        cond_flags_o[`MCAD_FL_NEG]   <= sum_negative_bit;
        cond_flags_o[`MCAD_FL_ULOW]  <= unsigned_low_wrap;
        cond_flags_o[`MCAD_FL_UHIGH] <= unsigned_high_wrap;
        cond_flags_o[`MCAD_FL_SLOW]  <= signed_low_wrap;
        cond_flags_o[`MCAD_FL_SO]    <= signed_high_wrap;
      end
      if (is_and) begin
        cond_flags_o[`MCAD_FL_MZERO] <= mask_all_zero;
        cond_flags_o[`MCAD_FL_MONES] <= mask_all_ones;
      end
      if (is_bias) begin
        cond_flags_o[`MCAD_FL_DENY] <= bias_allow != bias_sel;
        if (bias_state) begin
          bias_en_o <= bias_en_o | bias_allow;
        end else begin
          bias_en_o <= bias_en_o & ~bias_allow;
        end
      end
    end
  end

  // Read data decode
  reg  [31:0] rd_data;
  reg         rd_ok;
  wire [9:0]  rd_word = s_axi_araddr[11:2];
  wire [8:0]  probe_class = core_reg_class(probe_reg[4:0]);

  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (alu_hit(s_axi_araddr)) begin
      rd_data[DATA_W-1:0] = alu_operand_set_reg[s_axi_araddr[4:2]];
    end else if (s_axi_araddr == `MCAD_ADDR_FLAGS) begin
      rd_data[`MCAD_FLAGS_W-1:0] = cond_flags_o;
    end else if (s_axi_araddr == `MCAD_ADDR_BIAS) begin
      rd_data[`MCAD_BIAS_W-1:0] = bias_en_o;
    end else if (s_axi_araddr == `MCAD_ADDR_PROBE) begin
      rd_data[5:0]   = probe_reg;
      rd_data[16:8]  = probe_class;
      rd_data[20]    = general_ok(probe_reg[2:0]);
      rd_data[25:24] = jump_register_operand_set(probe_reg[5]);
    end else if (acc_hit(rd_word)) begin
      rd_data[15:0] = output_access_config_reg[rd_word[1:0]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI4-Lite handshakes
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MCAD_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `MCAD_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= {ADDR_W{1'b0}};
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg    <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg    <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // Response once both address and data are held
      if (wr_do) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `MCAD_RESP_OKAY : `MCAD_RESP_SLVERR;
      end
      // Readies return once the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_ok ? `MCAD_RESP_OKAY : `MCAD_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== mcad_sel.svh
`ifndef MCAD_SEL_SVH
`define MCAD_SEL_SVH
// Selector code to structure mask: [4:0] hs, [10:5] ls, [11] hs2 strong, [12] hs4 strong
function automatic logic [12:0] mcad_sel_mask(input logic [3:0] t);
  case (t)
    4'ha: return 13'h0800;
    4'hb: return 13'h1000;
    4'hc: return 13'h0400;
    4'hd: return 13'h1fff;
    4'he: return 13'h181f;
    4'hf: return 13'h07e0;
    default: return 13'h0001 << t;
  endcase
endfunction
`endif

// ===== mcad_code_ram.sv
`timescale 1ns/10ps
`default_nettype none
module mcad_code_ram (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  len_i,
  output var  logic [15:0] instr_o,
  output var  logic        valid_o,
  output var  logic        busy_o
);
  logic [15:0] mem [0:15];
  logic [3:0]  pc_reg;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      busy_o <= 1'b0;
      pc_reg <= 4'h0;
      instr_o <= 16'h0;
    end else if (busy_o) begin
      valid_o <= 1'b1;
      instr_o <= mem[pc_reg];
      pc_reg <= pc_reg + 4'h1;
      busy_o <= pc_reg != len_i - 4'h1;
    end else begin
      // Stale word inverted on every idle cycle
      valid_o <= 1'b0;
      instr_o <= ~instr_o;
      pc_reg <= 4'h0;
      busy_o <= start_i;
    end
  end
endmodule
`default_nettype wire

// ===== mcad_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcad_sel.svh"
module mcad_core_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [15:0] instr_i,
  input wire logic        instr_valid_i,
  input wire logic [12:0] bias_en_o,
  input wire logic [9:0]  cond_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [9:0]  f;
  logic [12:0] b;
  logic [12:0] sel_w;
  logic        add_w, sum_w, and_w, bias_w, none_w;
  assign f = cond_flags_o;
  assign b = bias_en_o;
  assign sel_w = mcad_sel_mask(instr_i[3:0]);
  assign add_w = instr_valid_i && instr_i[15:10] == 6'h0a && !instr_i[6];
  assign sum_w = add_w || (instr_valid_i && instr_i[15:10] == 6'h06);
  assign and_w = instr_valid_i && instr_i[15:3] == 13'h05d9;
  assign bias_w = instr_valid_i && instr_i[15:5] == 11'h1b1;
  assign none_w = instr_valid_i && !sum_w && !and_w && !bias_w;
  sum_carry_a: assert property (sum_w |=> f[0] == f[4] && !f[3])
    else $error("carry flags disagree");
  sum_sign_a: assert property (sum_w |=> !(f[1] && f[2]) && !(f[5] && f[6]))
    else $error("sign flags clash");
  sum_keep_a: assert property (sum_w |=> $stable(f[9:7]))
    else $error("mask flags moved on add");
  and_keep_a: assert property (and_w |=> $stable(f[6:0]) && !(f[7] && f[8]))
    else $error("and flags wrong");
  word_ignore_a: assert property (none_w |=> $stable(f) && $stable(b))
    else $error("unknown word had effect");
  bias_sel_a: assert property (bias_w |=> ((b ^ $past(b)) & ~$past(sel_w)) == 13'h0)
    else $error("unselected bias changed");
  bias_state_a: assert property (bias_w |=>
    ((b ^ $past(b)) & (b ^ {13{$past(instr_i[4])}})) == 13'h0)
    else $error("bias moved against state");
  bias_right_a: assert property (bias_w ##1 !f[9] |->
    ($past(sel_w) & (b ^ {13{$past(instr_i[4])}})) == 13'h0)
    else $error("granted bias not applied");
  cover property (sum_w ##1 f[6]);
  cover property (and_w ##1 f[8]);
  cover property (bias_w ##1 f[9]);
endmodule
bind mcad_core mcad_core_chk chk (.clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr_i),
  .instr_valid_i(instr_valid_i), .bias_en_o(bias_en_o), .cond_flags_o(cond_flags_o));
`default_nettype wire

// ===== tb_microcore_alu_bias_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcad_sel.svh"
module tb_microcore_alu_bias_decode;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        start, awvalid, wvalid, bready, arvalid, rready;
  logic        ivalid, busy, awready, wready, bvalid, arready, rvalid;
  logic [3:0]  len = 4'h0;
  logic [15:0] instr;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  logic [12:0] bias;
  logic [9:0]  flags;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [15:0] mk [3] = '{16'h0ff0, 16'hffff, 16'h0000};
  logic [15:0] dv [3] = '{16'h0f0f, 16'hffff, 16'h1234};
  initial {start, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
  initial forever #5 clk_i = ~clk_i;
  mcad_code_ram ram (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start), .len_i(len),
    .instr_o(instr), .valid_o(ivalid), .busy_o(busy));
  mcad_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr), .instr_valid_i(ivalid),
    .bias_en_o(bias), .cond_flags_o(flags), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for the answer as long as it takes; only the cycle ceiling ends a hang
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk(32'(bresp), 32'(er));
        done = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        done = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask
  // Streams n words from the code store, then lets the last result settle
  task automatic run(input int n);
    int k;
    k = 0;
    len <= 4'(n);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    @(posedge clk_i);
    while (busy && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    repeat (2) @(posedge clk_i);
  endtask
  function automatic logic [31:0] probe(input logic [5:0] c);
    logic [4:0] r;
    logic [4:0] cl;
    logic [4:0] ix;
    r = c[4:0];
    ix = 5'h0;
    cl = 5'(r - 5'd18);
    if (r < 8) begin
      cl = 5'h0;
      ix = r;
    end else if (r < 10) cl = 5'(r - 5'd7);
    else if (r < 12) begin
      cl = 5'h3;
      ix = 5'(r - 5'd10);
    end else if (r < 20) begin
      cl = r < 16 ? 5'h4 : 5'h5;
      ix = {3'h0, r[1:0]};
    end else if (r < 24) cl = 5'(r - 5'd14);
    else if (r < 29) begin
      cl = 5'ha;
      ix = 5'(r - 5'd24);
    end
    return {6'h0, c[5], !c[5], 3'h0, r[2:0] <= 3'd5, 3'h0, cl[3:0], 2'h0, ix[2:0], 2'h0, c};
  endfunction
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 10; i++) axr(12'(4 * i), 32'h0, 2'b00);
    for (int k = 0; k < 8; k++) begin
      axw(12'(4 * k), 32'h100 + k, 2'b00);
      ram.mem[k] = {6'h0a, 3'(k), 1'b0, 3'(k), 3'(k)};
    end
    run(8);
    for (int k = 0; k < 8; k++) axr(12'(4 * k), 32'h200 + 2 * k, 2'b00);
    $display("test operand set done");
    axw(12'h000, 32'h7fff, 2'b00);
    axw(12'h004, 32'h0001, 2'b00);
    ram.mem[0] = {6'h0a, 3'd2, 1'b0, 3'd1, 3'd0};
    ram.mem[1] = {6'h0a, 3'd3, 1'b0, 3'd2, 3'd2};
    run(2);
    axr(12'h008, 32'h8000, 2'b00);
    axr(12'h00c, 32'h0, 2'b00);
    chk(32'(flags), 32'h033);
    ram.mem[0] = {6'h0a, 3'd3, 1'b1, 3'd0, 3'd0};
    ram.mem[1] = {6'h06, 3'd4, 4'hf, 3'd0};
    run(2);
    axr(12'h00c, 32'h0, 2'b00);
    axr(12'h010, 32'h800e, 2'b00);
    chk(32'(flags), 32'h044);
    $display("test add done");
    for (int i = 0; i < 3; i++) begin
      axw(12'h014, 32'(mk[i]), 2'b00);
      axw(12'h004, 32'(dv[i]), 2'b00);
      ram.mem[0] = {13'h05d9, 3'd1};
      run(1);
      axr(12'h004, 32'(mk[i] & dv[i]), 2'b00);
      chk(flags[8:7], {(mk[i] & dv[i]) == 16'hffff, (mk[i] & dv[i]) == 16'h0});
    end
    $display("test mask done");
    for (int c = 0; c < 64; c++) begin
      axw(12'h028, 32'(c), 2'b00);
      axr(12'h028, probe(6'(c)), 2'b00);
    end
    $display("test operand codes done");
    axw(12'h610, 32'h0, 2'b00);
    ram.mem[0] = {11'h1b1, 1'b1, 4'h0};
    run(1);
    chk(flags[9], 1'b1);
    chk(32'(bias), 32'h0);
    axw(12'h610, 32'h7ff, 2'b00);
    for (int t = 0; t < 16; t++) begin
      ram.mem[0] = {11'h1b1, 1'b0, 4'hd};
      ram.mem[1] = {11'h1b1, 1'b1, 4'(t)};
      run(2);
      chk(32'(bias), 32'(mcad_sel_mask(4'(t))));
    end
    run(1);
    chk(32'(bias), 32'h0);
    axw(12'h610, 32'h2, 2'b00);
    axr(12'h610, 32'h2, 2'b00);
    ram.mem[0] = {11'h1b1, 1'b1, 4'he};
    run(1);
    chk(32'(bias), 32'h0802);
    chk(flags[9], 1'b1);
    axr(12'h024, 32'h0802, 2'b00);
    $display("test bias done");
    axw(12'h100, 32'h1, 2'b10);
    axr(12'h100, 32'h0, 2'b10);
    axw(12'h020, 32'h3ff, 2'b00);
    axr(12'h020, 32'h2c4, 2'b00);
    $display("test bus done");
    test_done();
  end
endmodule
`default_nettype wire
